// *** src/fcs_pkg.sv ***
// Package: register map, field positions, commands and types for the flash control block
package fcs_pkg;
   // Register byte offsets on the Avalon-MM slave
   localparam logic [4:0] OFS_CONFIG = 5'h00;
   localparam logic [4:0] OFS_PROTECTION = 5'h04;
   localparam logic [4:0] OFS_STATUS = 5'h08;
   localparam logic [4:0] OFS_COMMAND = 5'h0C;
   localparam logic [4:0] OFS_DIVIDER = 5'h10;
   localparam logic [4:0] OFS_CTRL = 5'h14;
   // Configuration fields
   localparam int CFG_KEY_BIT = 5;
   localparam logic [7:0] CFG_RW_MASK = 8'hE0;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // Protection fields
   localparam int PROT_DIS_BIT = 0;
   // Status fields
   localparam int ST_CBEF = 7;
   localparam int ST_CCF = 6;
   localparam int ST_PVIOL = 5;
   localparam int ST_ACCERR = 4;
   localparam int ST_BLANK = 2;
   // Divider register fields
   localparam int DIV_LOADED_BIT = 7;
   localparam logic [6:0] DIV_RESET = 7'h00;
   // Control register fields
   localparam int CTRL_STOP_BIT = 0;
   localparam int CTRL_ERASED_BIT = 1;
   // Commands
   localparam logic [7:0] CMD_BLANK = 8'h05;
   localparam logic [7:0] CMD_BYTE_PROG = 8'h20;
   localparam logic [7:0] CMD_BURST_PROG = 8'h25;
   localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
   localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
   localparam logic [7:0] CMD_RESET = 8'h00;
   // Flash geometry and protection granularity
   localparam int ADDR_W = 16;
   localparam int PAGE_BITS = 9;
   localparam logic [15:0] ERASED_BYTE = 16'h00FF;
   // Timing of array operations
   localparam int OP_TIME_NS = 5000;
   localparam int CLK_PERIOD_NS = 100;
   localparam logic [7:0] OP_CYCLES = 8'(OP_TIME_NS / CLK_PERIOD_NS);
   // Security codes
   localparam logic [1:0] SEC_UNSECURED = 2'b10;
   localparam logic [1:0] SEC_RESET = 2'b00;
   typedef enum logic [1:0] {FCS_IDLE, FCS_BUSY} fcs_phase_t;
   // Write into the backdoor key window from the CPU side
   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
   } fcs_arr_wr_t;
   typedef struct packed {
      logic [2:0] cfg;
      logic [7:0] prot;
      logic cbef;
      logic ccf;
      logic pviol;
      logic accerr;
      logic blank;
      logic [7:0] cmd;
      logic [6:0] div;
      logic div_loaded;
      logic staged;
      logic [ADDR_W-1:0] st_addr;
      logic [7:0] st_data;
      logic pend;
      logic [7:0] pend_cmd;
      logic [ADDR_W-1:0] pend_addr;
      logic [7:0] pend_data;
      fcs_phase_t phase;
      logic [7:0] op_cmd;
      logic [7:0] timer;
      logic [1:0] sec;
      logic key_strobe;
      logic arr_strobe;
      logic [ADDR_W-1:0] arr_addr;
      logic [7:0] arr_data;
      logic waitreq;
      logic [31:0] rdata;
      logic prot_load;
   } fcs_state_t;
endpackage

// *** src/fcs_flash_ctrl.sv ***
// Flash command, status and protection register block with Avalon-MM slave
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Key-access bit 0: key-window writes start a program or erase command.
// - Key-access bit 1: key-window writes are key compares; array reads invalid.
// - Config bits 7..5 read/write; bits 4..0 read zero, ignore writes.
// - Protection loaded from nonvolatile byte at reset; program writes ignored.
// - Debug-port writes to protection register are accepted.
// - Boundary select sets unprotected top region; protected program/erase refused.
// - Disable bit 0 protects selected block; 1 protects nothing.
// - Status bits 3, 1, 0 read zero and ignore writes.
// - Writing 1 to buffer-empty launches; it stays clear while a burst waits; burst transfer sets it.
// - Only burst program is buffered; buffer-empty shows room for another.
// - Complete sets when buffer empty and idle; clears on launch; ignores writes.
// - Protection violation sets on protected target, command ignored; write 1 clears.
// - Access error on bad sequence, no divider, or stop; write 1 clears.
// - Blank sets after blank check of erased array; new command clears.
// - Command codes 05, 20, 25, 40 (512-byte page), 41 recognised.
// - Any other code is illegal and raises access error.
// - Program and erase disabled until divider written; loaded bit shows it.
// - Successful blank check sets security code to unsecured 10.
module fcs_flash_ctrl (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire fcs_pkg::fcs_arr_wr_t arr_wr,
   input wire logic [7:0] nonvolatile_protection_byte,
   input wire logic dbg_prot_write,
   input wire logic [7:0] dbg_prot_data,
   input wire logic stop_entry,
   input wire logic array_erased,
   output logic key_write_enable,
   output logic key_strobe,
   output logic array_read_invalid,
   output logic arr_strobe,
   output logic [15:0] arr_addr,
   output logic [7:0] arr_data,
   output logic [7:0] arr_cmd,
   output logic [1:0] security_state_code
);
   import fcs_pkg::*;

   fcs_state_t q;
   fcs_state_t n;
   logic wr_acc;
   logic rd_acc;
   logic [7:0] wd;
   logic [7:0] rd8;
   logic launch;
   logic cmd_legal;
   logic is_prog;
   logic is_erase;
   logic prot_hit;
   logic [ADDR_W-1:0] boundary;
   logic accept;

   // Protected region is everything below the boundary page
   assign boundary = {q.prot[7:1], {PAGE_BITS{1'b0}}};

   always_comb begin
      n = q;
      n.key_strobe = 1'b0;
      n.arr_strobe = 1'b0;
      wr_acc = avs_write & ~q.waitreq;
      // Read data is captured one cycle early so it stands with the answer
      rd_acc = avs_read & q.waitreq;
      wd = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
      launch = 1'b0;
      accept = 1'b0;
      cmd_legal = (q.cmd == CMD_BLANK) || (q.cmd == CMD_BYTE_PROG) ||
         (q.cmd == CMD_BURST_PROG) || (q.cmd == CMD_PAGE_ERASE) ||
         (q.cmd == CMD_MASS_ERASE);
      is_prog = (q.cmd == CMD_BYTE_PROG) || (q.cmd == CMD_BURST_PROG);
      is_erase = (q.cmd == CMD_PAGE_ERASE) || (q.cmd == CMD_MASS_ERASE);
      prot_hit = ~q.prot[PROT_DIS_BIT] && (is_prog || is_erase) &&
         ((q.cmd == CMD_MASS_ERASE) || (q.st_addr < boundary));
      // One wait state per access gives a registered answer
      n.waitreq = ~((avs_read | avs_write) & q.waitreq);
      if (!(avs_read | avs_write)) begin
         n.waitreq = 1'b1;
      end
      // Protection is captured once after reset release
      if (q.prot_load) begin
         n.prot = nonvolatile_protection_byte;
         n.prot_load = 1'b0;
      end else if (dbg_prot_write) begin
         n.prot = dbg_prot_data;
      end
      if (rd_acc) begin
         unique case (avs_address)
            OFS_CONFIG: rd8 = {q.cfg, 5'b00000};
            OFS_PROTECTION: rd8 = q.prot;
            OFS_STATUS: rd8 = {q.cbef, q.ccf, q.pviol, q.accerr, 1'b0,
               q.blank, 2'b00};
            OFS_COMMAND: rd8 = q.cmd;
            OFS_DIVIDER: rd8 = {q.div_loaded, q.div};
            OFS_CTRL: rd8 = {6'h00, q.sec};
            default: rd8 = 8'h00;
         endcase
         n.rdata = {24'h000000, rd8};
      end else begin
         rd8 = 8'h00;
      end
      if (wr_acc && avs_byteenable[0]) begin
         unique case (avs_address)
            OFS_CONFIG: n.cfg = wd[7:5];
            OFS_COMMAND: n.cmd = wd;
            OFS_DIVIDER: begin
               n.div = wd[6:0];
               n.div_loaded = 1'b1;
            end
            OFS_STATUS: begin
               if (wd[ST_PVIOL]) n.pviol = 1'b0;
               if (wd[ST_ACCERR]) n.accerr = 1'b0;
               if (wd[ST_CBEF] && q.cbef) launch = 1'b1;
            end
            default: ;
         endcase
      end
      // Writes into the key window, after the clears so a set wins
      if (arr_wr.valid) begin
         if (q.cfg[CFG_KEY_BIT - 5]) begin
            n.key_strobe = 1'b1;
         end else if (q.cbef) begin
            n.staged = 1'b1;
            n.st_addr = arr_wr.addr;
            n.st_data = arr_wr.data;
         end else begin
            n.accerr = 1'b1;
         end
      end
      if (launch) begin
         n.cbef = 1'b0;
         n.ccf = 1'b0;
         n.staged = 1'b0;
         // Only burst program may wait behind a running command
         if (!cmd_legal || (!q.staged && q.cmd != CMD_MASS_ERASE &&
               q.cmd != CMD_BLANK) || q.accerr || q.pviol ||
               (q.phase == FCS_BUSY && q.cmd != CMD_BURST_PROG)) begin
            n.accerr = 1'b1;
         end else if ((is_prog || is_erase) && !q.div_loaded) begin
            n.accerr = 1'b1;
         end else if (prot_hit) begin
            n.pviol = 1'b1;
         end else begin
            accept = 1'b1;
            n.blank = 1'b0;
         end
         if (!accept && q.phase == FCS_IDLE) begin
            n.cbef = 1'b1;
            n.ccf = 1'b1;
         end else if (!accept) begin
            n.cbef = 1'b1;
         end
      end
      if (accept) begin
         if (q.phase == FCS_IDLE) begin
            n.phase = FCS_BUSY;
            n.op_cmd = q.cmd;
            n.timer = OP_CYCLES;
            n.arr_strobe = 1'b1;
            n.arr_addr = q.st_addr;
            n.arr_data = q.st_data;
            n.cbef = 1'b1;
         end else begin
            // Burst program queued behind the active one
            n.pend = 1'b1;
            n.pend_cmd = q.cmd;
            n.pend_addr = q.st_addr;
            n.pend_data = q.st_data;
         end
      end
      if (q.phase == FCS_BUSY) begin
         if (stop_entry) begin
            n.accerr = 1'b1;
            n.phase = FCS_IDLE;
            n.pend = 1'b0;
            n.cbef = 1'b1;
            n.ccf = 1'b1;
         end else if (q.timer != 8'h00) begin
            n.timer = q.timer - 8'h01;
         end else if (q.pend) begin
            n.pend = 1'b0;
            n.op_cmd = q.pend_cmd;
            n.timer = OP_CYCLES;
            n.arr_strobe = 1'b1;
            n.arr_addr = q.pend_addr;
            n.arr_data = q.pend_data;
            n.cbef = ~launch;
         end else begin
            n.phase = FCS_IDLE;
            n.ccf = n.cbef;
            if (q.op_cmd == CMD_BLANK && array_erased) begin
               n.blank = 1'b1;
               n.sec = SEC_UNSECURED;
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.cfg <= CFG_RESET[7:5];
         q.cbef <= 1'b1;
         q.ccf <= 1'b1;
         q.cmd <= CMD_RESET;
         q.div <= DIV_RESET;
         q.phase <= FCS_IDLE;
         q.sec <= SEC_RESET;
         q.waitreq <= 1'b1;
         q.prot_load <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // Outputs are taken from the state register
   assign avs_readdata = q.rdata;
   assign avs_waitrequest = q.waitreq;
   assign key_write_enable = q.cfg[CFG_KEY_BIT - 5];
   assign array_read_invalid = q.cfg[CFG_KEY_BIT - 5];
   assign key_strobe = q.key_strobe;
   assign arr_strobe = q.arr_strobe;
   assign arr_addr = q.arr_addr;
   assign arr_data = q.arr_data;
   assign arr_cmd = q.op_cmd;
   assign security_state_code = q.sec;

   AST_CFG_LOW_ZERO: assert property (@(posedge core_clk) disable iff (rst)
      $rose(avs_waitrequest) && $past(avs_read) &&
      $past(avs_address) == OFS_CONFIG |-> avs_readdata[4:0] == 5'h00)
      else $error("config low bits not zero");
   AST_STATUS_ZERO: assert property (@(posedge core_clk) disable iff (rst)
      $past(avs_read) && $past(avs_address) == OFS_STATUS &&
      !$past(avs_waitrequest) |-> avs_readdata[3] == 1'b0 &&
      avs_readdata[1:0] == 2'b00)
      else $error("status reserved bits not zero");
   AST_KEY_STROBE: assert property (@(posedge core_clk) disable iff (rst)
      arr_wr.valid && q.cfg[CFG_KEY_BIT - 5] |=> key_strobe && !q.staged)
      else $error("key write not routed to compare");
   AST_NO_DIV_NO_PROG: assert property (@(posedge core_clk) disable iff (rst)
      arr_strobe |-> q.div_loaded || q.op_cmd == CMD_BLANK)
      else $error("array operation before divider loaded");
   AST_ILLEGAL_CMD: assert property (@(posedge core_clk) disable iff (rst)
      launch && !cmd_legal |=> q.accerr && !arr_strobe)
      else $error("illegal command not flagged");
   AST_PVIOL: assert property (@(posedge core_clk) disable iff (rst)
      launch && cmd_legal && q.staged && !q.accerr && !q.pviol &&
      q.div_loaded && prot_hit |=> q.pviol && !arr_strobe)
      else $error("protected target not refused");
   AST_LAUNCH_CLEARS: assert property (@(posedge core_clk) disable iff (rst)
      accept && q.phase == FCS_IDLE |=> !q.ccf ##0 arr_strobe)
      else $error("launch did not start command");
   sequence s_blank_done;
      q.phase == FCS_BUSY && q.timer == 8'h00 && !q.pend && !stop_entry &&
         q.op_cmd == CMD_BLANK && array_erased;
   endsequence
   AST_BLANK_SEC: assert property (@(posedge core_clk) disable iff (rst)
      s_blank_done |=> q.blank && security_state_code == SEC_UNSECURED)
      else $error("blank check did not unsecure");
   AST_STOP_ERR: assert property (@(posedge core_clk) disable iff (rst)
      q.phase == FCS_BUSY && stop_entry |=> q.accerr && q.phase == FCS_IDLE)
      else $error("stop during command not flagged");
   AST_PROT_RO: assert property (@(posedge core_clk) disable iff (rst)
      !q.prot_load && !dbg_prot_write |=> $stable(q.prot))
      else $error("protection changed without debug write");
   AST_WAIT_STANDS: assert property (
      @(posedge core_clk) disable iff (rst)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   AST_BUS_ANSWER: assert property (
      @(posedge core_clk) disable iff (rst)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait state");
   AST_RDATA_TOP: assert property (
      @(posedge core_clk) disable iff (rst)
      avs_readdata[31:8] == 24'h000000)
      else $error("read data upper bytes not zero");
   AST_CFG_WRITE: assert property (
      @(posedge core_clk) disable iff (rst)
      avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address == OFS_CONFIG |=>
      key_write_enable == $past(avs_writedata[5]))
      else $error("config write not taken");
   AST_KEY_MIRROR: assert property (
      @(posedge core_clk) disable iff (rst)
      key_write_enable == array_read_invalid)
      else $error("array read invalid not tied to key enable");
   AST_KEY_NONE: assert property (
      @(posedge core_clk) disable iff (rst)
      arr_wr.valid && !key_write_enable |=> !key_strobe)
      else $error("key compare seen while key access off");
   AST_STAGE: assert property (
      @(posedge core_clk) disable iff (rst)
      arr_wr.valid && !key_write_enable && q.cbef && !launch |=>
      q.staged && q.st_addr == $past(arr_wr.addr))
      else $error("window write not staged as command data");
   AST_PROT_LOAD: assert property (
      @(posedge core_clk) disable iff (rst)
      $fell(q.prot_load) |-> q.prot == $past(nonvolatile_protection_byte))
      else $error("protection not loaded from nonvolatile byte");
   AST_DBG_WRITE: assert property (
      @(posedge core_clk) disable iff (rst)
      !q.prot_load && dbg_prot_write |=> q.prot == $past(dbg_prot_data))
      else $error("debug protection write not taken");
   AST_PVIOL_CLEAR: assert property (
      @(posedge core_clk) disable iff (rst)
      avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address == OFS_STATUS && avs_writedata[ST_PVIOL] |=> !q.pviol)
      else $error("violation flag not cleared by write one");
   AST_ARR_LEGAL: assert property (
      @(posedge core_clk) disable iff (rst)
      arr_strobe |-> arr_cmd == CMD_BLANK || arr_cmd == CMD_BYTE_PROG ||
      arr_cmd == CMD_BURST_PROG || arr_cmd == CMD_PAGE_ERASE ||
      arr_cmd == CMD_MASS_ERASE)
      else $error("unknown command handed to array");
   AST_STROBE_TIMER: assert property (
      @(posedge core_clk) disable iff (rst)
      arr_strobe |-> q.timer == OP_CYCLES && q.phase == FCS_BUSY)
      else $error("array strobe without a full operation time");
   AST_STROBE_PULSE: assert property (
      @(posedge core_clk) disable iff (rst)
      arr_strobe |=> !arr_strobe)
      else $error("array strobe longer than one cycle");
   AST_PEND_FULL: assert property (
      @(posedge core_clk) disable iff (rst)
      q.pend |-> !q.cbef)
      else $error("buffer empty shown while buffer full");
   AST_PEND_BURST: assert property (
      @(posedge core_clk) disable iff (rst)
      q.pend |-> q.pend_cmd == CMD_BURST_PROG)
      else $error("non-burst command buffered");
   AST_CCF_IDLE: assert property (
      @(posedge core_clk) disable iff (rst)
      q.phase == FCS_IDLE && q.cbef |-> q.ccf)
      else $error("complete flag low while idle and empty");
   AST_BUSY_CCF: assert property (
      @(posedge core_clk) disable iff (rst)
      q.phase == FCS_BUSY |-> !q.ccf)
      else $error("complete flag high while busy");
   sequence s_accept_idle;
      accept && q.phase == FCS_IDLE;
   endsequence
   AST_BLANK_CLEAR: assert property (
      @(posedge core_clk) disable iff (rst)
      s_accept_idle |=> !q.blank)
      else $error("blank flag not cleared by new command");
   AST_STOP_NO_STROBE: assert property (
      @(posedge core_clk) disable iff (rst)
      q.phase == FCS_BUSY && stop_entry |=> !arr_strobe)
      else $error("array strobe after stop entry");
   AST_DIV_STICKY: assert property (
      @(posedge core_clk) disable iff (rst)
      q.div_loaded |=> q.div_loaded)
      else $error("divider loaded bit lost");
   AST_SEC_STICKY: assert property (
      @(posedge core_clk) disable iff (rst)
      security_state_code == SEC_UNSECURED |=>
      security_state_code == SEC_UNSECURED)
      else $error("unsecured state lost");
   AST_SEC_SOURCE: assert property (
      @(posedge core_clk) disable iff (rst)
      $changed(security_state_code) |->
      $past(q.op_cmd) == CMD_BLANK && $past(array_erased))
      else $error("security code changed without good blank check");
endmodule

// *** test/fcs_cpu_model.sv ***
// CPU-side Avalon-MM master model that issues the register cycles
`timescale 1ns/1ps
module fcs_cpu_model (
   input wire logic core_clk,
   output logic [4:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest
);
   initial begin
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
   end

   // One bus cycle; software orders data, command, launch itself
   task automatic cyc(input logic [4:0] a, input logic rd,
                      input logic [7:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= 4'hF;
      avs_read <= rd;
      avs_write <= !rd;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // Released lines must not keep the last value
      avs_address <= ~a;
      avs_writedata <= ~{24'h0, d};
   endtask
endmodule

// *** test/flash_command_status_control_bench.sv ***
// Self-checking bench for the flash command and status register block
`timescale 1ns/1ps
module flash_command_status_control_bench;
   import fcs_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   fcs_arr_wr_t arr_wr;
   logic [7:0] nvp, dbg_prot_data, arr_data, arr_cmd;
   logic dbg_prot_write, stop_entry, array_erased, key_write_enable;
   logic key_strobe, array_read_invalid, arr_strobe;
   logic [15:0] arr_addr, e;
   logic [1:0] security_state_code;
   int n_errors = 0;
   int checks = 0;
   int nks = 0;
   logic [15:0] rq[$];
   logic [31:0] aq[$];
   logic [31:0] lfsr = 32'hD3C4;
   logic [7:0] cl[5] = '{CMD_BLANK, CMD_BYTE_PROG, CMD_BURST_PROG,
                         CMD_PAGE_ERASE, CMD_MASS_ERASE};

   always #50 core_clk = ~core_clk;

   fcs_flash_ctrl fcs_flash_ctrl_i (.core_clk(core_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .arr_wr(arr_wr),
      .nonvolatile_protection_byte(nvp), .dbg_prot_write(dbg_prot_write),
      .dbg_prot_data(dbg_prot_data), .stop_entry(stop_entry),
      .array_erased(array_erased), .key_write_enable(key_write_enable),
      .key_strobe(key_strobe), .array_read_invalid(array_read_invalid),
      .arr_strobe(arr_strobe), .arr_addr(arr_addr), .arr_data(arr_data),
      .arr_cmd(arr_cmd), .security_state_code(security_state_code));

   fcs_cpu_model fcs_cpu_model_i (.core_clk(core_clk),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest));

   function logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Masked read: note mask and value, the monitor compares
   task automatic rd(input logic [4:0] a, input logic [7:0] m,
                     input logic [7:0] v);
      rq.push_back({m, v});
      fcs_cpu_model_i.cyc(a, 1'b1, 8'h00);
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      fcs_cpu_model_i.cyc(a, 1'b0, d);
   endtask

   task automatic launch(input logic [7:0] c, input logic [15:0] a,
                         input logic ok, input int w);
      logic [7:0] d;
      d = 8'(rnd());
      if (ok) aq.push_back({c, a, d});
      @(posedge core_clk);
      arr_wr <= '{1'b1, a, d};
      @(posedge core_clk);
      arr_wr.valid <= 1'b0;
      wr(OFS_COMMAND, c);
      wr(OFS_STATUS, 8'h80);
      repeat (w) @(posedge core_clk);
   endtask

   always @(posedge core_clk) begin
      if (avs_read && avs_waitrequest === 1'b0) begin
         e = rq.pop_front();
         check("register", {24'h0, avs_readdata[7:0] & e[15:8]},
               {24'h0, e[7:0]});
      end
      if (arr_strobe === 1'b1) begin
         check("array", {arr_cmd, arr_addr, arr_data}, aq.pop_front());
      end
      if (key_strobe === 1'b1) nks++;
   end

   initial begin
      arr_wr = '0;
      nvp = 8'h01;
      dbg_prot_write = 1'b0;
      dbg_prot_data = 8'h00;
      stop_entry = 1'b0;
      array_erased = 1'b0;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      rd(OFS_STATUS, 8'hFF, 8'hC0);
      rd(OFS_PROTECTION, 8'hFF, 8'h01);
      wr(OFS_CONFIG, 8'hFF);
      rd(OFS_CONFIG, 8'hFF, 8'hE0);
      check("key enable", key_write_enable, 1'b1);
      check("read invalid", array_read_invalid, 1'b1);
      @(posedge core_clk);
      arr_wr <= '{1'b1, 16'hFFB0, 8'h5A};
      @(posedge core_clk);
      arr_wr.valid <= 1'b0;
      wr(OFS_CONFIG, 8'h00);
      wr(OFS_PROTECTION, 8'h00);
      rd(OFS_PROTECTION, 8'hFF, 8'h01);
      rd(5'h18, 8'hFF, 8'h00);
      launch(CMD_BYTE_PROG, 16'h9000, 1'b0, 60);
      rd(OFS_STATUS, 8'h30, 8'h10);
      wr(OFS_STATUS, 8'h30);
      rd(OFS_DIVIDER, 8'h80, 8'h00);
      wr(OFS_DIVIDER, 8'h31);
      rd(OFS_DIVIDER, 8'h80, 8'h80);
      launch(8'h33, 16'h9000, 1'b0, 60);
      wr(OFS_STATUS, 8'h00);
      rd(OFS_STATUS, 8'h30, 8'h10);
      wr(OFS_STATUS, 8'h30);
      rd(OFS_STATUS, 8'hFF, 8'hC0);
      foreach (cl[i]) begin
         array_erased <= (cl[i] == CMD_BLANK);
         launch(cl[i], 16'h8000 | 16'(rnd() & 32'h7FFF), 1'b1, 60);
         rd(OFS_STATUS, 8'hFF, (i == 0) ? 8'hC4 : 8'hC0);
      end
      launch(CMD_BURST_PROG, 16'h8100, 1'b1, 0);
      launch(CMD_BURST_PROG, 16'h8101, 1'b1, 0);
      rd(OFS_STATUS, 8'hC0, 8'h00);
      repeat (120) @(posedge core_clk);
      rd(OFS_STATUS, 8'hFF, 8'hC0);
      rd(OFS_CTRL, 8'h03, 8'h02);
      @(posedge core_clk);
      dbg_prot_write <= 1'b1;
      dbg_prot_data <= 8'h80;
      @(posedge core_clk);
      dbg_prot_write <= 1'b0;
      rd(OFS_PROTECTION, 8'hFF, 8'h80);
      launch(CMD_BYTE_PROG, 16'h1000, 1'b0, 60);
      rd(OFS_STATUS, 8'h20, 8'h20);
      wr(OFS_STATUS, 8'h20);
      launch(CMD_PAGE_ERASE, 16'hA000, 1'b1, 60);
      rd(OFS_STATUS, 8'hFF, 8'hC0);
      launch(CMD_PAGE_ERASE, 16'hA200, 1'b1, 2);
      stop_entry <= 1'b1;
      @(posedge core_clk);
      stop_entry <= 1'b0;
      repeat (60) @(posedge core_clk);
      rd(OFS_STATUS, 8'h10, 8'h10);
      check("key strobes", nks, 1);
      check("strobes left", aq.size(), 0);
      stop_test();
   end

   initial begin
      #1000000;
      n_errors++;
      stop_test();
   end
endmodule
